/* File: bcu_top.sv */
/*
  Branch, jump, compare and skip control of an 8-bit core, reached as an
  APB slave. Software loads operands, pc, Z pointer and flags, then
  writes a command; the block resolves the next pc and holds busy for one cycle less than the
  instruction's cycle count. Assumes a single clock and one APB master.
*/
`timescale 1ns/1ns

module bcu_top
  import bcu_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  ce,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [BCU_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  output logic                       busy,
  output logic [BCU_PC_W-1:0]        pc_out
);

  bcu_regs_t r_reg;
  bcu_regs_t r_next;

  logic [7:0] rd_v;
  logic [7:0] rr_v;
  logic [7:0] io_v;
  logic [7:0] ofs_v;
  logic [4:0] op_raw;
  bcu_op_t    op;
  logic [2:0] bsel;
  logic       two_word;
  logic       op_legal;
  logic       access_first;
  logic       done;
  logic       issue;
  bcu_cmp_t   cmp_flags;
  logic       cmp_eq;

  assign rd_v     = r_reg.oper[BCU_OPER_RD_LSB +: 8];
  assign rr_v     = r_reg.oper[BCU_OPER_RR_LSB +: 8];
  assign io_v     = r_reg.oper[BCU_OPER_IO_LSB +: 8];
  assign ofs_v    = r_reg.oper[BCU_OPER_OFS_LSB +: 8];
  assign op_raw   = pwdata[BCU_CMD_OP_LSB +: 5];
  assign op       = bcu_op_t'(op_raw);
  assign bsel     = pwdata[BCU_CMD_BIT_LSB +: 3];
  assign two_word = pwdata[BCU_CMD_TWO_BIT];
  assign op_legal = (op_raw >= BCU_OP_FIRST) && (op_raw <= BCU_OP_LAST);

  // first access cycle gets the wait state; the second one completes
  assign access_first = psel & penable & ~r_reg.pready;
  assign done         = psel & penable & r_reg.pready & ~r_reg.pslverr;
  assign issue        = done & pwrite & (paddr == BCU_CMD_ADDR);

  // immediate operand for compare rides in the rr field
  bcu_cmp u_cmp (
    .a     (rd_v),
    .b     (rr_v),
    .flags (cmp_flags),
    .eq    (cmp_eq)
  );

  always_comb
  begin
    logic       skip;
    logic       br;
    logic       is_skip;
    logic       is_branch;
    logic [1:0] cyc;
    logic [7:0] fl;
    skip      = 1'b0;
    br        = 1'b0;
    is_skip   = 1'b0;
    is_branch = 1'b0;
    cyc       = BCU_CYC_ONE;
    fl        = r_reg.flags;
    r_next    = r_reg;
    r_next.pready  = 1'b0;
    r_next.pslverr = 1'b0;

    if (access_first)
    begin
      r_next.pready = 1'b1;
      r_next.prdata = 32'h0000_0000;
      unique case (paddr)
        BCU_CMD_ADDR:
        begin
          // a command while busy or an unknown code is refused
          r_next.pslverr = pwrite & (r_reg.busy | ~op_legal);
        end
        BCU_OPER_ADDR:
        begin
          r_next.prdata = r_reg.oper;
        end
        BCU_PC_ADDR:
        begin
          r_next.prdata[BCU_PC_W-1:0] = r_reg.pc;
          r_next.pslverr = pwrite & r_reg.busy;
        end
        BCU_ZPTR_ADDR:
        begin
          r_next.prdata[BCU_PC_W-1:0] = r_reg.zptr;
          r_next.pslverr = pwrite & r_reg.busy;
        end
        BCU_FLAGS_ADDR:
        begin
          r_next.prdata[7:0] = r_reg.flags;
          r_next.pslverr = pwrite & r_reg.busy;
        end
        BCU_STATUS_ADDR:
        begin
          r_next.prdata[BCU_STAT_BUSY_BIT]  = r_reg.busy;
          r_next.prdata[BCU_STAT_TAKEN_BIT] = r_reg.taken;
          r_next.prdata[BCU_STAT_CYC_LSB +: 2] = r_reg.last_cyc;
          r_next.pslverr = pwrite;
        end
        default:
        begin
          r_next.pslverr = 1'b1;
        end
      endcase
    end

    // pc and flags are committed at the end of the last cycle
    if (r_reg.fsm == st_exec)
    begin
      r_next.cnt = r_reg.cnt - 2'h1;
      if (r_reg.cnt == 2'h1)
      begin
        r_next.fsm   = st_idle;
        r_next.busy  = 1'b0;
        r_next.pc    = r_reg.pend_pc;
        r_next.flags = r_reg.pend_flags;
      end
    end

    if (done & pwrite)
    begin
      unique case (paddr)
        BCU_OPER_ADDR:  r_next.oper  = pwdata;
        BCU_PC_ADDR:    r_next.pc    = pwdata[BCU_PC_W-1:0];
        BCU_ZPTR_ADDR:  r_next.zptr  = pwdata[BCU_PC_W-1:0];
        BCU_FLAGS_ADDR: r_next.flags = pwdata[7:0];
        default:
        begin
        end
      endcase
    end

    if (issue)
    begin
      r_next.pend_flags = r_reg.flags;
      r_next.pend_pc    = bcu_pc_add(r_reg.pc, 8'h00, BCU_ADV_NEXT);
      // every code from the status-bit branches upward is a relative branch
      is_branch = (op >= branch_status_bit_clear_op);
      unique case (op)
        indirect_jump_op:
        begin
          r_next.pend_pc = r_reg.zptr;
          cyc = BCU_CYC_INDIRECT_JUMP_OP;
          br  = 1'b1;
        end
        indirect_call_op:
        begin
          r_next.pend_pc = r_reg.zptr;
          cyc = BCU_CYC_INDIRECT_CALL_OP;
          br  = 1'b1;
        end
        compare_skip_equal_op:
        begin
          is_skip = 1'b1;
          skip    = cmp_eq;
        end
        compare_immediate_op:
        begin
          r_next.pend_flags.z = cmp_flags.z;
          r_next.pend_flags.n = cmp_flags.n;
          r_next.pend_flags.v = cmp_flags.v;
          r_next.pend_flags.c = cmp_flags.c;
          r_next.pend_flags.h = cmp_flags.h;
        end
        skip_reg_bit_clear_op:
        begin
          is_skip = 1'b1;
          skip    = ~rd_v[bsel];
        end
        skip_io_bit_clear_op:
        begin
          is_skip = 1'b1;
          skip    = ~io_v[bsel];
        end
        branch_status_bit_clear_op: br = ~fl[bsel];
        branch_status_bit_set_op:   br = fl[bsel];
        branch_signed_ge_op:        br = ~(r_reg.flags.n ^ r_reg.flags.v);
        branch_half_carry_set_op:   br = r_reg.flags.h;
        branch_half_carry_clear_op: br = ~r_reg.flags.h;
        branch_tbit_set_op:         br = r_reg.flags.t;
        branch_tbit_clear_op:       br = ~r_reg.flags.t;
        branch_overflow_set_op:     br = r_reg.flags.v;
        branch_unsigned_ge_op:      br = ~r_reg.flags.c;
        branch_unsigned_lt_op:      br = r_reg.flags.c;
        branch_carry_clear_op:      br = ~r_reg.flags.c;
        branch_carry_set_op:        br = r_reg.flags.c;
        branch_not_equal_op:        br = ~r_reg.flags.z;
        branch_equal_op:            br = r_reg.flags.z;
        branch_negative_op:         br = r_reg.flags.n;
        branch_positive_op:         br = ~r_reg.flags.n;
        default:
        begin
        end
      endcase

      if (is_branch && br)
      begin
        r_next.pend_pc = bcu_pc_add(r_reg.pc, ofs_v, BCU_ADV_NEXT);
        cyc = BCU_CYC_BR_TKN;
      end
      if (is_skip && skip)
      begin
        r_next.pend_pc = bcu_pc_add(r_reg.pc, 8'h00,
                                    two_word ? BCU_ADV_SKIP2 : BCU_ADV_SKIP1);
        cyc = two_word ? BCU_CYC_SKIP2 : BCU_CYC_SKIP1;
      end

      r_next.taken    = br | skip;
      r_next.last_cyc = cyc;
      r_next.cnt      = cyc - 2'h1;
      if (cyc == BCU_CYC_ONE)
      begin
        r_next.pc    = r_next.pend_pc;
        r_next.flags = r_next.pend_flags;
      end
      else
      begin
        r_next.fsm  = st_exec;
        r_next.busy = 1'b1;
      end
    end
  end

  // clock enable freezes every flip-flop, the bus answer included
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_reg            <= '0;
      r_reg.fsm        <= st_idle;
      r_reg.pc         <= BCU_PC_RST;
      r_reg.flags      <= BCU_FLAGS_RST;
      r_reg.pend_flags <= BCU_FLAGS_RST;
    end
    else if (ce)
    begin
      r_reg <= r_next;
    end
  end

  assign pready  = r_reg.pready;
  assign prdata  = r_reg.prdata;
  assign pslverr = r_reg.pslverr;
  assign busy    = r_reg.busy;
  assign pc_out  = r_reg.pc;

  property p_indirect_jump_op;
    @(posedge pclk) disable iff (!presetn || !ce)
    issue && op == indirect_jump_op |-> ##1 busy ##1
      (!busy && pc_out == $past(r_reg.zptr, 2) && r_reg.flags == $past(r_reg.flags, 2));
  endproperty
  a_indirect_jump_op: assert property (p_indirect_jump_op) else $error("indirect jump wrong");

  property p_indirect_call_op;
    @(posedge pclk) disable iff (!presetn || !ce)
    issue && op == indirect_call_op |-> ##1 busy [*2] ##1
      (!busy && pc_out == $past(r_reg.zptr, 3));
  endproperty
  a_indirect_call_op: assert property (p_indirect_call_op) else $error("indirect call wrong");

  property p_compare_skip_equal_op;
    @(posedge pclk) disable iff (!presetn || !ce)
    issue && op == compare_skip_equal_op && cmp_eq && !two_word |->
      ##2 (pc_out == $past(r_reg.pc, 2) + 16'h0002);
  endproperty
  a_compare_skip_equal_op: assert property (p_compare_skip_equal_op) else $error("compare skip wrong");

  property p_cpi;
    @(posedge pclk) disable iff (!presetn || !ce)
    issue && op == compare_immediate_op |-> ##1
      (!busy && r_reg.flags.c == $past(cmp_flags.c) && r_reg.flags.z == $past(cmp_flags.z));
  endproperty
  a_cpi: assert property (p_cpi) else $error("compare immediate wrong");

  property p_skip_reg_bit_clear_op_noskip;
    @(posedge pclk) disable iff (!presetn || !ce)
    issue && op == skip_reg_bit_clear_op && rd_v[bsel] |->
      ##1 (pc_out == $past(r_reg.pc) + 16'h0001);
  endproperty
  a_skip_reg_bit_clear_op_noskip: assert property (p_skip_reg_bit_clear_op_noskip) else $error("bit skip wrong");

  property p_branch_status_bit_clear_op_taken;
    @(posedge pclk) disable iff (!presetn || !ce)
    issue && op == branch_status_bit_clear_op && !r_reg.flags[bsel] |-> ##1 busy ##1
      (pc_out == bcu_pc_add($past(r_reg.pc, 2), $past(ofs_v, 2), BCU_ADV_NEXT));
  endproperty
  a_branch_status_bit_clear_op_taken: assert property (p_branch_status_bit_clear_op_taken) else $error("branch target wrong");

  property p_branch_signed_ge_op_untaken;
    @(posedge pclk) disable iff (!presetn || !ce)
    issue && op == branch_signed_ge_op && (r_reg.flags.n ^ r_reg.flags.v) |->
      ##1 (!busy && pc_out == $past(r_reg.pc) + 16'h0001);
  endproperty
  a_branch_signed_ge_op_untaken: assert property (p_branch_signed_ge_op_untaken) else $error("signed branch wrong");

  property p_skip_two;
    @(posedge pclk) disable iff (!presetn || !ce)
    issue && op == skip_io_bit_clear_op && !io_v[bsel] && two_word |->
      ##1 busy [*2] ##1 (pc_out == $past(r_reg.pc, 3) + 16'h0003);
  endproperty
  a_skip_two: assert property (p_skip_two) else $error("long skip wrong");

endmodule : bcu_top

/* File: bcu_pkg.sv */
/*
  Package for the branch and skip control block: register map, field
  positions, cycle counts, operation codes and the packed carriers.
  Assumes a 32-bit APB slave with a 12-bit byte address.
*/
package bcu_pkg;

  localparam int unsigned BCU_ADDR_W = 12;
  localparam int unsigned BCU_PC_W   = 16;

  // register byte offsets
  localparam logic [11:0] BCU_CMD_ADDR    = 12'h000;
  localparam logic [11:0] BCU_OPER_ADDR   = 12'h004;
  localparam logic [11:0] BCU_PC_ADDR     = 12'h008;
  localparam logic [11:0] BCU_ZPTR_ADDR   = 12'h00C;
  localparam logic [11:0] BCU_FLAGS_ADDR  = 12'h010;
  localparam logic [11:0] BCU_STATUS_ADDR = 12'h014;

  // command fields
  localparam int unsigned BCU_CMD_OP_LSB  = 0;
  localparam int unsigned BCU_CMD_BIT_LSB = 5;
  localparam int unsigned BCU_CMD_TWO_BIT = 8;

  // operand fields
  localparam int unsigned BCU_OPER_RD_LSB  = 0;
  localparam int unsigned BCU_OPER_RR_LSB  = 8;
  localparam int unsigned BCU_OPER_IO_LSB  = 16;
  localparam int unsigned BCU_OPER_OFS_LSB = 24;

  // status fields
  localparam int unsigned BCU_STAT_BUSY_BIT  = 0;
  localparam int unsigned BCU_STAT_TAKEN_BIT = 1;
  localparam int unsigned BCU_STAT_CYC_LSB   = 4;

  // cycle counts
  localparam logic [1:0] BCU_CYC_INDIRECT_JUMP_OP   = 2'h2;
  localparam logic [1:0] BCU_CYC_INDIRECT_CALL_OP  = 2'h3;
  localparam logic [1:0] BCU_CYC_ONE    = 2'h1;
  localparam logic [1:0] BCU_CYC_BR_TKN = 2'h2;
  localparam logic [1:0] BCU_CYC_SKIP1  = 2'h2;
  localparam logic [1:0] BCU_CYC_SKIP2  = 2'h3;

  // program counter advances in words
  localparam logic [1:0] BCU_ADV_NEXT  = 2'h1;
  localparam logic [1:0] BCU_ADV_SKIP1 = 2'h2;
  localparam logic [1:0] BCU_ADV_SKIP2 = 2'h3;

  localparam logic [BCU_PC_W-1:0] BCU_PC_RST    = 16'h0000;
  localparam logic [7:0]          BCU_FLAGS_RST = 8'h00;

  typedef enum logic [4:0] {
    indirect_jump_op           = 5'h01,
    indirect_call_op           = 5'h02,
    compare_skip_equal_op      = 5'h03,
    compare_immediate_op       = 5'h04,
    skip_reg_bit_clear_op      = 5'h05,
    skip_io_bit_clear_op       = 5'h06,
    branch_status_bit_clear_op = 5'h07,
    branch_status_bit_set_op   = 5'h08,
    branch_signed_ge_op        = 5'h09,
    branch_half_carry_set_op   = 5'h0A,
    branch_half_carry_clear_op = 5'h0B,
    branch_tbit_set_op         = 5'h0C,
    branch_tbit_clear_op       = 5'h0D,
    branch_overflow_set_op     = 5'h0E,
    branch_unsigned_ge_op      = 5'h0F,
    branch_unsigned_lt_op      = 5'h10,
    branch_carry_clear_op      = 5'h11,
    branch_carry_set_op        = 5'h12,
    branch_not_equal_op        = 5'h13,
    branch_equal_op            = 5'h14,
    branch_negative_op         = 5'h15,
    branch_positive_op         = 5'h16
  } bcu_op_t;

  localparam logic [4:0] BCU_OP_FIRST = 5'h01;
  localparam logic [4:0] BCU_OP_LAST  = 5'h16;

  typedef enum logic {
    st_idle = 1'b0,
    st_exec = 1'b1
  } bcu_state_t;

  // status_flags_register layout, bit 7 down to bit 0
  typedef struct packed {
    logic i;
    logic t;
    logic h;
    logic s;
    logic v;
    logic n;
    logic z;
    logic c;
  } bcu_flags_t;

  typedef struct packed {
    logic h;
    logic s;
    logic v;
    logic n;
    logic z;
    logic c;
  } bcu_cmp_t;

  typedef struct packed {
    bcu_state_t            fsm;
    logic                  busy;
    logic [1:0]            cnt;
    logic [BCU_PC_W-1:0]   pc;
    logic [BCU_PC_W-1:0]   zptr;
    bcu_flags_t            flags;
    logic [31:0]           oper;
    logic [BCU_PC_W-1:0]   pend_pc;
    bcu_flags_t            pend_flags;
    logic                  taken;
    logic [1:0]            last_cyc;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
  } bcu_regs_t;

  // pc plus sign-extended offset plus a small advance
  function automatic logic [BCU_PC_W-1:0] bcu_pc_add(
    input logic [BCU_PC_W-1:0] pc,
    input logic [7:0]          ofs,
    input logic [1:0]          adv
  );
    logic [BCU_PC_W-1:0] ext;
    ext = {{(BCU_PC_W-8){ofs[7]}}, ofs};
    return pc + ext + {{(BCU_PC_W-2){1'b0}}, adv};
  endfunction : bcu_pc_add

endpackage : bcu_pkg

/* File: bcu_cmp.sv */
/*
  Byte comparator: forms a minus b without keeping it and reports the
  flags of the subtraction. Purely combinational, same clock as caller.
*/
`timescale 1ns/1ns
module bcu_cmp
  import bcu_pkg::*;
(
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  output bcu_cmp_t        flags,
  output logic            eq
);

  logic [7:0] diff;

  assign diff    = a - b;
  assign eq      = (a == b);
  assign flags.z = (diff == 8'h00);
  assign flags.n = diff[7];
  // borrow out of bit 7 and bit 3
  assign flags.c = (~a[7] & b[7]) | (b[7] & diff[7]) | (diff[7] & ~a[7]);
  assign flags.h = (~a[3] & b[3]) | (b[3] & diff[3]) | (diff[3] & ~a[3]);
  assign flags.v = (a[7] & ~b[7] & ~diff[7]) | (~a[7] & b[7] & diff[7]);
  assign flags.s = flags.n ^ flags.v;

endmodule : bcu_cmp

/* File: test_branch_skip_control.sv */
/*
  Self-checking bench for the branch and skip control block.
  Assumes bcu_pkg and bcu_top are compiled first; drives APB from the bench.
*/
`timescale 1ns/1ns
module test_branch_skip_control
  import bcu_pkg::*;
;
  logic                  pclk;
  logic                  presetn;
  logic                  ce;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [BCU_ADDR_W-1:0] paddr;
  logic [31:0]           pwdata;
  logic                  pready;
  logic [31:0]           prdata;
  logic                  pslverr;
  logic                  busy;
  logic [BCU_PC_W-1:0]   pc_out;
  logic [31:0]           rd_data;
  logic                  rd_err;
  int                    errors;
  int                    cmp_count;

  bcu_top DUT (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pready  (pready),
    .prdata  (prdata),
    .pslverr (pslverr),
    .busy    (busy),
    .pc_out  (pc_out)
  );

  always #10 pclk = ~pclk;

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // request held until the edge that samples pready high
  task automatic apb_xfer(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (n == 16)
    begin
      errors++;
      results();
    end
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb_xfer

  task automatic apb_wr(input logic [11:0] addr, input logic [31:0] data, input logic err);
    apb_xfer(1'b1, addr, data);
    check(32'(rd_err), 32'(err));
  endtask : apb_wr

  task automatic apb_rd(input logic [11:0] addr, input logic [31:0] exp, input logic err);
    apb_xfer(1'b0, addr, 32'h0000_0000);
    check(32'(rd_err), 32'(err));
    if (!err)
      check(rd_data, exp);
  endtask : apb_rd

  // load operands, issue one command, measure busy and the result
  task automatic exec(input logic [4:0] op, input logic [2:0] bsel, input logic two,
                      input logic [31:0] oper, input logic [15:0] pc0, input logic [15:0] z,
                      input logic [7:0] fl, input logic [15:0] exp_pc, input logic [1:0] cyc,
                      input logic tk, input logic [7:0] exp_fl);
    int          c;
    int          i;
    logic [31:0] st_mask;
    apb_wr(BCU_OPER_ADDR, oper, 1'b0);
    apb_wr(BCU_PC_ADDR, {16'h0000, pc0}, 1'b0);
    apb_wr(BCU_ZPTR_ADDR, {16'h0000, z}, 1'b0);
    apb_wr(BCU_FLAGS_ADDR, {24'h00_0000, fl}, 1'b0);
    apb_wr(BCU_CMD_ADDR, {23'h00_0000, two, bsel, op}, 1'b0);
    c = 1;
    for (i = 0; i < 8; i++)
    begin
      @(posedge pclk);
      if (busy !== 1'b1)
        break;
      c++;
    end
    if (i == 8)
    begin
      errors++;
      results();
    end
    check(32'(pc_out), 32'(exp_pc));
    check(32'(c), 32'(cyc));
    // taken bit has no clear meaning for jumps and compare, so it is masked there
    st_mask = (op == indirect_jump_op || op == indirect_call_op || op == compare_immediate_op)
              ? 32'hFFFF_FFFD : 32'hFFFF_FFFF;
    apb_xfer(1'b0, BCU_STATUS_ADDR, 32'h0000_0000);
    check(rd_data & st_mask, {26'h000_0000, cyc, 2'h0, tk, 1'b0} & st_mask);
    apb_rd(BCU_FLAGS_ADDR, {24'h00_0000, exp_fl}, 1'b0);
  endtask : exec

  function automatic logic cond(input logic [4:0] op, input logic [2:0] b, input bcu_flags_t f);
    case (op)
      branch_status_bit_clear_op: return ~f[b];
      branch_status_bit_set_op:   return f[b];
      branch_signed_ge_op:        return ~(f.n ^ f.v);
      branch_half_carry_set_op:   return f.h;
      branch_half_carry_clear_op: return ~f.h;
      branch_tbit_set_op:         return f.t;
      branch_tbit_clear_op:       return ~f.t;
      branch_overflow_set_op:     return f.v;
      branch_unsigned_ge_op:      return ~f.c;
      branch_unsigned_lt_op:      return f.c;
      branch_carry_clear_op:      return ~f.c;
      branch_carry_set_op:        return f.c;
      branch_not_equal_op:        return ~f.z;
      branch_equal_op:            return f.z;
      branch_negative_op:         return f.n;
      branch_positive_op:         return ~f.n;
      default:                    return 1'b0;
    endcase
  endfunction : cond

  task automatic t_reset();
    check(32'(pc_out), 32'h0000_0000);
    check(32'(busy), 32'h0000_0000);
    apb_rd(BCU_PC_ADDR, 32'h0000_0000, 1'b0);
    apb_rd(BCU_ZPTR_ADDR, 32'h0000_0000, 1'b0);
    apb_rd(BCU_FLAGS_ADDR, 32'h0000_0000, 1'b0);
    apb_rd(BCU_STATUS_ADDR, 32'h0000_0000, 1'b0);
    apb_wr(BCU_OPER_ADDR, 32'hDEAD_BEEF, 1'b0);
    apb_rd(BCU_OPER_ADDR, 32'hDEAD_BEEF, 1'b0);
    apb_rd(BCU_CMD_ADDR, 32'h0000_0000, 1'b0);
  endtask : t_reset

  task automatic t_indirect();
    exec(indirect_jump_op, 3'h0, 1'b0, 32'h0, 16'h0100, 16'h1234, 8'hFF,
         16'h1234, 2'h2, 1'b1, 8'hFF);
    exec(indirect_call_op, 3'h0, 1'b0, 32'h0, 16'h0200, 16'hBEEF, 8'h5A,
         16'hBEEF, 2'h3, 1'b1, 8'h5A);
  endtask : t_indirect

  task automatic t_skip();
    exec(compare_skip_equal_op, 3'h0, 1'b0, 32'h0000_5A5A, 16'h0300, 16'h0, 8'hA5,
         16'h0302, 2'h2, 1'b1, 8'hA5);
    exec(compare_skip_equal_op, 3'h0, 1'b1, 32'h0000_5A5A, 16'h0300, 16'h0, 8'hA5,
         16'h0303, 2'h3, 1'b1, 8'hA5);
    exec(compare_skip_equal_op, 3'h0, 1'b1, 32'h0000_5A5B, 16'h0300, 16'h0, 8'hA5,
         16'h0301, 2'h1, 1'b0, 8'hA5);
    exec(skip_reg_bit_clear_op, 3'h3, 1'b0, 32'h0000_00F7, 16'h0300, 16'h0, 8'hA5,
         16'h0302, 2'h2, 1'b1, 8'hA5);
    exec(skip_reg_bit_clear_op, 3'h3, 1'b0, 32'h0000_0008, 16'h0300, 16'h0, 8'hA5,
         16'h0301, 2'h1, 1'b0, 8'hA5);
    exec(skip_io_bit_clear_op, 3'h6, 1'b1, 32'h00BF_0000, 16'h0300, 16'h0, 8'hA5,
         16'h0303, 2'h3, 1'b1, 8'hA5);
    exec(skip_io_bit_clear_op, 3'h6, 1'b1, 32'h0040_00FF, 16'h0300, 16'h0, 8'hA5,
         16'h0301, 2'h1, 1'b0, 8'hA5);
  endtask : t_skip

  // expected flags worked by hand; S is left as it was
  task automatic t_cpi();
    exec(compare_immediate_op, 3'h0, 1'b0, 32'h0000_2010, 16'h0400, 16'h0, 8'hC0,
         16'h0401, 2'h1, 1'b0, 8'hC5);
    exec(compare_immediate_op, 3'h0, 1'b0, 32'h0000_0180, 16'h0400, 16'h0, 8'h10,
         16'h0401, 2'h1, 1'b0, 8'h38);
    exec(compare_immediate_op, 3'h0, 1'b0, 32'h0000_3A3A, 16'h0400, 16'h0, 8'hFF,
         16'h0401, 2'h1, 1'b0, 8'hD2);
  endtask : t_cpi

  task automatic t_branch();
    logic [7:0] fl_tab [4];
    logic       tk;
    fl_tab = '{8'h00, 8'hFF, 8'h08, 8'h35};
    for (int op = 7; op <= 22; op++)
      for (int j = 0; j < 4; j++)
      begin
        tk = cond(5'(op), 3'(j * 3), bcu_flags_t'(fl_tab[j]));
        exec(5'(op), 3'(j * 3), 1'b0, 32'hF000_0000, 16'h0200, 16'h0, fl_tab[j],
             tk ? 16'h01F1 : 16'h0201, tk ? 2'h2 : 2'h1, tk, fl_tab[j]);
      end
  endtask : t_branch

  task automatic t_offset();
    exec(branch_equal_op, 3'h0, 1'b0, 32'h7F00_0000, 16'hFFF0, 16'h0, 8'h02,
         16'h0070, 2'h2, 1'b1, 8'h02);
    exec(branch_negative_op, 3'h0, 1'b0, 32'h8000_0000, 16'h0005, 16'h0, 8'h04,
         16'hFF86, 2'h2, 1'b1, 8'h04);
  endtask : t_offset

  task automatic t_refused();
    apb_wr(BCU_PC_ADDR, 32'h0000_0ABC, 1'b0);
    apb_rd(12'h018, 32'h0000_0000, 1'b1);
    apb_wr(BCU_STATUS_ADDR, 32'h0000_0001, 1'b1);
    apb_wr(BCU_CMD_ADDR, 32'h0000_0000, 1'b1);
    apb_wr(BCU_CMD_ADDR, 32'h0000_0017, 1'b1);
    apb_rd(BCU_PC_ADDR, 32'h0000_0ABC, 1'b0);
    check(32'(pc_out), 32'h0000_0ABC);
    check(32'(busy), 32'h0000_0000);
  endtask : t_refused

  // clock enable low freezes a running call; a mid-run reset clears a running jump
  task automatic t_freeze();
    apb_wr(BCU_PC_ADDR, 32'h0000_0111, 1'b0);
    apb_wr(BCU_ZPTR_ADDR, 32'h0000_4321, 1'b0);
    apb_wr(BCU_CMD_ADDR, 32'h0000_0002, 1'b0);
    ce <= 1'b0;
    repeat (4) @(posedge pclk);
    check(32'(busy), 32'h0000_0001);
    check(32'(pc_out), 32'h0000_0111);
    ce <= 1'b1;
    repeat (3) @(posedge pclk);
    check(32'(busy), 32'h0000_0000);
    check(32'(pc_out), 32'h0000_4321);
    apb_wr(BCU_CMD_ADDR, 32'h0000_0001, 1'b0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check(32'(busy), 32'h0000_0000);
    check(32'(pc_out), 32'h0000_0000);
    presetn <= 1'b1;
    apb_rd(BCU_ZPTR_ADDR, 32'h0000_0000, 1'b0);
  endtask : t_freeze

  initial
  begin
    errors    = 0;
    cmp_count = 0;
    pclk      = 1'b0;
    presetn   = 1'b0;
    ce        = 1'b1;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h000;
    pwdata    = 32'h0000_0000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_indirect();
    t_skip();
    t_cpi();
    t_branch();
    t_offset();
    t_refused();
    t_freeze();
    results();
  end
endmodule : test_branch_skip_control
